// *** rtl/pmsa_pkg.sv ***
// Constants and types for the power-management status and arbiter control block
// Notes on behaviour
// [R01] An active chassis intrusion input sets the intrusion flag, which stays set after the input goes inactive.
// [R02] Once set, the intrusion flag holds whatever the input does until software attempts a clear.
// [R03] A software write-one clear of the intrusion flag may take up to 65 us to take effect.
// [R04] While the intrusion input is active a software clear is ignored, because set wins over clear.
// [R05] The RTC power-lost flag, bit 2 of config register three, is set while the RTC-well reset pin is low.
// [R06] Writing zero to bit 2 clears the RTC power-lost flag.
// [R07] A fall of core voltage good sets the CPU power-fail flag (bit 1) unless it comes from an excused transition.
// [R08] Writing zero to bit 1 clears the CPU power-fail flag.
// [R09] Arbiter-off bit 0 enables the upstream arbiter when 0 and blocks upstream traffic when 1.
// [R10] With the upstream arbiter off, the PCI arbiter keeps running and granting.
// [R11] The processor must not start downstream reads to PCI devices holding posted data while the arbiter is off.
// [R12] Software should avoid non-posted accesses and handlers should check arbiter-off while it is set.
// [R13] Software must mask every I/O interrupt before entering mobile light sleep.
// [R14] The asynchronous intrusion input passes a two-stage synchroniser before setting the flag.
package pmsa_pkg;

	// ----------------------------------------
	// Timing
	// ----------------------------------------
	localparam int CLOCK_PERIOD_NS       = 20;
	localparam int CLEAR_RECOVERY_NS     = 65000;
	localparam int CLEAR_RECOVERY_CYCLES = CLEAR_RECOVERY_NS / CLOCK_PERIOD_NS;
	localparam int CLEAR_COUNT_WIDTH     = 12;

	// ----------------------------------------
	// Field positions
	// ----------------------------------------
	localparam int RTC_LOST_BIT = 2;
	localparam int CPU_FAIL_BIT = 1;
	localparam int ARB_OFF_BIT  = 0;
	localparam int REG_WIDTH    = 8;

	// ----------------------------------------
	// Reset values
	// ----------------------------------------
	localparam logic INTRUSION_RESET = 1'b0;
	localparam logic RTC_LOST_RESET  = 1'b0;
	localparam logic CPU_FAIL_RESET  = 1'b0;
	localparam logic ARB_OFF_RESET   = 1'b0;

	typedef enum logic [0:0] {
		CLR_IDLE = 1'b0,
		CLR_WAIT = 1'b1
	} pmsa_clear_state_t;

endpackage

// *** rtl/pmsa_top.sv ***
// Power-management status flags and upstream arbiter control
`timescale 1ns/1ps
module pmsa_top (
	input  wire logic                               clk,
	input  wire logic                               reset_n,
	input  wire logic                               intrusionPin_n,
	input  wire logic                               intrusionClearWe,
	input  wire logic                               rtcWellResetPin_n,
	input  wire logic                               pmConfigThreeWe,
	input  wire logic [pmsa_pkg::REG_WIDTH-1:0]     pmConfigThreeData,
	input  wire logic                               coreVoltageGood,
	input  wire logic                               voltageTransitionActive,
	input  wire logic                               deeperIdleActive,
	input  wire logic                               lightSleepActive,
	input  wire logic                               deepSleepEnable,
	input  wire logic                               pmConfigTwoWe,
	input  wire logic [pmsa_pkg::REG_WIDTH-1:0]     pmConfigTwoData,
	input  wire logic                               pmSecondControlWe,
	input  wire logic [pmsa_pkg::REG_WIDTH-1:0]     pmSecondControlData,
	output logic                                    intrusionDetectedFlag,
	output logic                                    intrusionClearPending,
	output logic                                    rtcPowerLostFlag,
	output logic                                    cpuPowerFailFlag,
	output logic                                    upstreamArbiterOff,
	output logic                                    upstreamGrantEnable,
	output logic                                    pciArbiterEnable
);

	// ----------------------------------------
	// Intrusion synchroniser
	// ----------------------------------------
	logic intrSyncA;
	logic intrSyncB;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			intrSyncA <= 1'b1;
			intrSyncB <= 1'b1;
		end else begin
			intrSyncA <= intrusionPin_n; // see [R14]
			intrSyncB <= intrSyncA; // see [R14]
		end
	end

	logic intrActive;
	assign intrActive = ~intrSyncB;

	// ----------------------------------------
	// Intrusion flag and clear recovery
	// ----------------------------------------
	pmsa_pkg::pmsa_clear_state_t             clrState;
	pmsa_pkg::pmsa_clear_state_t             next_clrState;
	logic [pmsa_pkg::CLEAR_COUNT_WIDTH-1:0]  clrCount;
	logic [pmsa_pkg::CLEAR_COUNT_WIDTH-1:0]  next_clrCount;
	logic                                    next_intrusionDetectedFlag;
	logic                                    next_intrusionClearPending;

	localparam logic [pmsa_pkg::CLEAR_COUNT_WIDTH-1:0] CLR_LAST =
		pmsa_pkg::CLEAR_COUNT_WIDTH'(pmsa_pkg::CLEAR_RECOVERY_CYCLES - 1);

	always_comb begin
		next_clrState = clrState;
		next_clrCount = clrCount;
		next_intrusionDetectedFlag = intrusionDetectedFlag;
		unique case (clrState)
			pmsa_pkg::CLR_IDLE: begin
				if (intrusionClearWe && intrusionDetectedFlag && !intrActive) begin
					next_clrState = pmsa_pkg::CLR_WAIT; // see [R03]
					next_clrCount = '0;
				end
			end
			pmsa_pkg::CLR_WAIT: begin
				if (intrActive) begin
					next_clrState = pmsa_pkg::CLR_IDLE; // see [R04]
				end else if (clrCount == CLR_LAST) begin
					next_clrState = pmsa_pkg::CLR_IDLE;
					next_intrusionDetectedFlag = 1'b0; // see [R03]
				end else begin
					next_clrCount = clrCount + 1'b1;
				end
			end
		endcase
		if (intrActive) begin
			next_intrusionDetectedFlag = 1'b1; // see [R01] see [R02] see [R04]
		end
		next_intrusionClearPending = (next_clrState == pmsa_pkg::CLR_WAIT);
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			clrState              <= pmsa_pkg::CLR_IDLE;
			clrCount              <= '0;
			intrusionDetectedFlag <= pmsa_pkg::INTRUSION_RESET;
			intrusionClearPending <= 1'b0;
		end else begin
			clrState              <= next_clrState;
			clrCount              <= next_clrCount;
			intrusionDetectedFlag <= next_intrusionDetectedFlag;
			intrusionClearPending <= next_intrusionClearPending;
		end
	end

	// ----------------------------------------
	// RTC and CPU power status
	// ----------------------------------------
	logic prevVoltageGood;
	logic next_prevVoltageGood;
	logic next_rtcPowerLostFlag;
	logic next_cpuPowerFailFlag;
	logic voltageFell;
	logic fallExcused;

	always_comb begin
		voltageFell = prevVoltageGood && !coreVoltageGood;
		fallExcused = voltageTransitionActive || deeperIdleActive ||
			(lightSleepActive && deepSleepEnable);
		next_prevVoltageGood = coreVoltageGood;
		next_rtcPowerLostFlag = rtcPowerLostFlag;
		next_cpuPowerFailFlag = cpuPowerFailFlag;
		if (pmConfigThreeWe && !pmConfigThreeData[pmsa_pkg::RTC_LOST_BIT]) begin
			next_rtcPowerLostFlag = 1'b0; // see [R06]
		end
		if (!rtcWellResetPin_n) begin
			next_rtcPowerLostFlag = 1'b1; // see [R05]
		end
		if (pmConfigTwoWe && !pmConfigTwoData[pmsa_pkg::CPU_FAIL_BIT]) begin
			next_cpuPowerFailFlag = 1'b0; // see [R08]
		end
		if (voltageFell && !fallExcused) begin
			next_cpuPowerFailFlag = 1'b1; // see [R07]
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			prevVoltageGood  <= 1'b0;
			rtcPowerLostFlag <= pmsa_pkg::RTC_LOST_RESET;
			cpuPowerFailFlag <= pmsa_pkg::CPU_FAIL_RESET;
		end else begin
			prevVoltageGood  <= next_prevVoltageGood;
			rtcPowerLostFlag <= next_rtcPowerLostFlag;
			cpuPowerFailFlag <= next_cpuPowerFailFlag;
		end
	end

	// ----------------------------------------
	// Arbiter control
	// ----------------------------------------
	logic next_upstreamArbiterOff;
	logic next_upstreamGrantEnable;
	logic next_pciArbiterEnable;

	always_comb begin
		next_upstreamArbiterOff = upstreamArbiterOff;
		if (pmSecondControlWe) begin
			next_upstreamArbiterOff = pmSecondControlData[pmsa_pkg::ARB_OFF_BIT]; // see [R09]
		end
		next_upstreamGrantEnable = !next_upstreamArbiterOff; // see [R09]
		next_pciArbiterEnable = 1'b1; // see [R10]
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			upstreamArbiterOff  <= pmsa_pkg::ARB_OFF_RESET;
			upstreamGrantEnable <= !pmsa_pkg::ARB_OFF_RESET;
			pciArbiterEnable    <= 1'b1;
		end else begin
			upstreamArbiterOff  <= next_upstreamArbiterOff;
			upstreamGrantEnable <= next_upstreamGrantEnable;
			pciArbiterEnable    <= next_pciArbiterEnable;
		end
	end

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	a_intrusion_sets: assert property ( // see [R01]
		@(posedge clk) disable iff (!reset_n)
		intrActive |=> intrusionDetectedFlag)
		else $error("intrusion flag not set by active input");

	a_intrusion_holds: assert property ( // see [R02]
		@(posedge clk) disable iff (!reset_n)
		intrusionDetectedFlag && !intrusionClearWe && clrState == pmsa_pkg::CLR_IDLE
		|=> intrusionDetectedFlag)
		else $error("intrusion flag dropped without a clear");

	a_clear_latency: assert property ( // see [R03]
		@(posedge clk) disable iff (!reset_n)
		clrState == pmsa_pkg::CLR_WAIT && clrCount == CLR_LAST && !intrActive
		|=> !intrusionDetectedFlag && clrState == pmsa_pkg::CLR_IDLE)
		else $error("intrusion clear did not finish at its recovery count");

	a_clear_bound: assert property ( // see [R03]
		@(posedge clk) disable iff (!reset_n)
		clrState == pmsa_pkg::CLR_WAIT |-> clrCount <= CLR_LAST && intrusionClearPending)
		else $error("intrusion clear waited too long");

	a_set_priority: assert property ( // see [R04]
		@(posedge clk) disable iff (!reset_n)
		intrActive && intrusionClearWe |=> intrusionDetectedFlag && clrState == pmsa_pkg::CLR_IDLE)
		else $error("clear took effect while intrusion active");

	a_rtc_set: assert property ( // see [R05]
		@(posedge clk) disable iff (!reset_n)
		!rtcWellResetPin_n |=> rtcPowerLostFlag)
		else $error("rtc power-lost flag not set");

	a_rtc_clear: assert property ( // see [R06]
		@(posedge clk) disable iff (!reset_n)
		pmConfigThreeWe && !pmConfigThreeData[pmsa_pkg::RTC_LOST_BIT] && rtcWellResetPin_n
		|=> !rtcPowerLostFlag)
		else $error("rtc power-lost flag not cleared");

	a_cpu_set: assert property ( // see [R07]
		@(posedge clk) disable iff (!reset_n)
		$fell(coreVoltageGood) && !fallExcused |=> cpuPowerFailFlag)
		else $error("cpu power-fail flag not set");

	a_cpu_excused: assert property ( // see [R07]
		@(posedge clk) disable iff (!reset_n)
		!cpuPowerFailFlag && !(voltageFell && !fallExcused) |=> !cpuPowerFailFlag)
		else $error("cpu power-fail flag set without cause");

	a_cpu_clear: assert property ( // see [R08]
		@(posedge clk) disable iff (!reset_n)
		pmConfigTwoWe && !pmConfigTwoData[pmsa_pkg::CPU_FAIL_BIT] && !voltageFell
		|=> !cpuPowerFailFlag)
		else $error("cpu power-fail flag not cleared");

	a_arbiter_off: assert property ( // see [R09]
		@(posedge clk) disable iff (!reset_n)
		pmSecondControlWe |=> upstreamArbiterOff == $past(pmSecondControlData[0])
		&& upstreamGrantEnable == !upstreamArbiterOff)
		else $error("arbiter-off bit or upstream grant wrong");

	a_pci_running: assert property ( // see [R10]
		@(posedge clk) disable iff (!reset_n)
		upstreamArbiterOff |-> pciArbiterEnable && !upstreamGrantEnable)
		else $error("pci arbiter stopped with upstream arbiter off");

	a_sync_depth: assert property ( // see [R14]
		@(posedge clk) disable iff (!reset_n)
		intrusionPin_n ##2 !intrusionDetectedFlag |=> !intrusionDetectedFlag)
		else $error("intrusion input bypassed the synchroniser");

endmodule // pmsa_top

// *** dv/pmsa_host_model.sv ***
// Far-side model: processor sleep entry and processor downstream read traffic
`timescale 1ns/1ps
module pmsa_host_model (
	input  wire logic clk,
	input  wire logic reset_n,
	input  wire logic sleepReq,
	input  wire logic upstreamArbiterOff,
	output logic      lightSleepActive,
	output logic      downReadReq
);
	logic irqMasked;

	always @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			irqMasked        <= 1'b0;
			lightSleepActive <= 1'b0;
			downReadReq      <= 1'b0;
		end else begin
			irqMasked        <= sleepReq;
			lightSleepActive <= sleepReq & irqMasked;
			downReadReq      <= !upstreamArbiterOff;
		end
	end
endmodule // pmsa_host_model

// *** dv/tb_pm_status_and_arbiter_control.sv ***
// Self-checking bench for the power-management status and arbiter block
`timescale 1ns/1ps
module tb_pm_status_and_arbiter_control;
	logic       clk = 1'b0, reset_n = 1'b0, intrN = 1'b1, clrWe = 1'b0, rtcN = 1'b1, good = 1'b1;
	logic       trans = 1'b0, idle = 1'b0, sleepReq = 1'b0, deep = 1'b0;
	logic       we2 = 1'b0, we3 = 1'b0, weC = 1'b0;
	logic [7:0] d2 = 8'h00, d3 = 8'h00, dC = 8'h00;
	logic       intrFlag, pend, rtcFlag, cpuFlag, arbOff, grant, pciEn, light, downRd;
	int         n_fail = 0, comparisons = 0, n;
	// Row bits: transition, deeper idle, sleep request, deep sleep, arbiter off, expected fail flag
	logic [5:0] rows [6] = '{6'h03, 6'h22, 6'h10, 6'h0e, 6'h09, 6'h05};

	always #10 clk = ~clk;

	pmsa_top dut (.clk(clk), .reset_n(reset_n), .intrusionPin_n(intrN), .intrusionClearWe(clrWe),
		.rtcWellResetPin_n(rtcN), .pmConfigThreeWe(we3), .pmConfigThreeData(d3), .coreVoltageGood(good),
		.voltageTransitionActive(trans), .deeperIdleActive(idle), .lightSleepActive(light),
		.deepSleepEnable(deep), .pmConfigTwoWe(we2), .pmConfigTwoData(d2), .pmSecondControlWe(weC),
		.pmSecondControlData(dC), .intrusionDetectedFlag(intrFlag), .intrusionClearPending(pend),
		.rtcPowerLostFlag(rtcFlag), .cpuPowerFailFlag(cpuFlag), .upstreamArbiterOff(arbOff),
		.upstreamGrantEnable(grant), .pciArbiterEnable(pciEn));

	pmsa_host_model host (.clk(clk), .reset_n(reset_n), .sleepReq(sleepReq), .upstreamArbiterOff(arbOff),
		.lightSleepActive(light), .downReadReq(downRd));

	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	task automatic tick(input int k);
		repeat (k) @(posedge clk);
		#1;
	endtask

	task automatic chk(input string what, input logic exp, input logic got);
		comparisons++;
		if (got !== exp) begin
			$display("[ERR] %s expected %b seen %b", what, exp, got);
			n_fail++;
		end
	endtask

	task automatic wr(input int sel, input logic [7:0] v);
		if (sel == 2) begin
			we2 = 1'b1;
			d2  = v;
		end else if (sel == 3) begin
			we3 = 1'b1;
			d3  = v;
		end else begin
			weC = 1'b1;
			dC  = v;
		end
		tick(1);
		we2 = 1'b0;
		we3 = 1'b0;
		weC = 1'b0;
	endtask

	task automatic complete_run;
		$display("Counts: %0d comparisons, %0d mismatches", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask

	// ----------------------------------------
	// Sequence
	// ----------------------------------------
	initial begin
		tick(2);
		reset_n = 1'b1;
		tick(1);
		chk("reset outputs", 1'b1, {intrFlag, pend, rtcFlag, cpuFlag, arbOff, grant, pciEn} === 7'h03);
		$display("Test reset done");
		for (int i = 0; i < 6; i++) begin
			{trans, idle, sleepReq, deep} = rows[i][5:2];
			wr(0, {7'h00, rows[i][1]});
			tick(3);
			chk("arbiter off", rows[i][1], arbOff);
			chk("upstream grant", !rows[i][1], grant);
			chk("pci arbiter", 1'b1, pciEn);
			chk("down reads held", !rows[i][1], downRd);
			good = 1'b0;
			tick(2);
			chk("cpu fail flag", rows[i][0], cpuFlag);
			good = 1'b1;
			{trans, idle, sleepReq, deep} = 4'h0;
			tick(1);
			wr(2, 8'hfd);
			tick(1);
			chk("cpu fail cleared", 1'b0, cpuFlag);
		end
		$display("Test table done");
		rtcN = 1'b0;
		tick(2);
		chk("rtc lost set", 1'b1, rtcFlag);
		wr(3, 8'h00);
		tick(1);
		chk("rtc clear while low", 1'b1, rtcFlag);
		rtcN = 1'b1;
		wr(3, 8'h04);
		tick(1);
		chk("rtc write one", 1'b1, rtcFlag);
		wr(3, 8'hfb);
		tick(1);
		chk("rtc cleared", 1'b0, rtcFlag);
		$display("Test rtc done");
		intrN = 1'b0;
		tick(2);
		chk("intrusion synchroniser", 1'b0, intrFlag);
		tick(1);
		chk("intrusion set", 1'b1, intrFlag);
		clrWe = 1'b1;
		tick(1);
		clrWe = 1'b0;
		tick(1);
		chk("clear while active", 1'b0, pend);
		chk("flag while active", 1'b1, intrFlag);
		intrN = 1'b1;
		tick(4);
		chk("intrusion held", 1'b1, intrFlag);
		clrWe = 1'b1;
		tick(1);
		clrWe = 1'b0;
		tick(1);
		chk("clear pending", 1'b1, pend);
		n = 1;
		while (intrFlag === 1'b1 && n < 4000) begin
			tick(1);
			n++;
		end
		chk("recovery bounded", 1'b1, n < 4000);
		if (n >= 4000)
			complete_run();
		chk("recovery cycles", 1'b1, n == pmsa_pkg::CLEAR_RECOVERY_CYCLES);
		chk("pending dropped", 1'b0, pend);
		$display("Test intrusion done");
		intrN = 1'b0;
		tick(3);
		chk("intrusion set again", 1'b1, intrFlag);
		intrN = 1'b1;
		tick(3);
		clrWe = 1'b1;
		tick(1);
		clrWe = 1'b0;
		intrN = 1'b0;
		chk("clear accepted", 1'b1, pend);
		tick(4);
		chk("clear aborted", 1'b0, pend);
		chk("flag kept on abort", 1'b1, intrFlag);
		intrN = 1'b1;
		$display("Test abort done");
		wr(0, 8'h01);
		rtcN = 1'b0;
		tick(1);
		rtcN = 1'b1;
		reset_n = 1'b0;
		tick(2);
		reset_n = 1'b1;
		tick(1);
		chk("second reset outputs", 1'b1, {intrFlag, pend, rtcFlag, cpuFlag, arbOff, grant, pciEn} === 7'h03);
		$display("Test second reset done");
		complete_run();
	end
endmodule // tb_pm_status_and_arbiter_control
